/* File: hw/ilm_pkg.sv */
// ilm_pkg: constants shared by the interrupt level mask block
// assumes a 32-bit classic wishbone slave, byte addresses
package ilm_pkg;
    localparam int ILM_LEVELS = 8;
    localparam int ILM_ADDR_W = 10;
    // register index, not a byte address: times four on the bus
    localparam logic [7:0] ILM_MASK_INDEX = 8'hdd;
    localparam logic [ILM_ADDR_W-1:0] ILM_MASK_ADDR = {ILM_MASK_INDEX, 2'b00};
    localparam logic [ILM_ADDR_W-1:0] ILM_STATUS_ADDR = 10'h000;
    localparam int ILM_BIT_TIMER_A = 0;
    localparam int ILM_BIT_TIMER_B = 1;
    localparam int ILM_BIT_UART = 5;
    localparam logic [7:0] ILM_MASK_RESET = 8'h00;
    localparam logic [31:0] ILM_ERR_DATA = 32'h0000_0000;
    typedef enum logic [1:0] {
        ILM_IDLE = 2'b00,
        ILM_ACK = 2'b01
    } ilm_state_t;
endpackage

/* File: hw/ilm_gate_if.sv */
// ilm_gate_if: mask and request bundle between top and gate
// assumes one clock domain
`timescale 1ns/1ns
interface ilm_gate_if #(parameter int N = 8);
    logic [N-1:0] mask;
    logic [N-1:0] raw;
    logic [N-1:0] visible;
    modport top (output mask, output raw, input visible);
    modport gate (input mask, input raw, output visible);
endinterface

/* File: hw/ilm_gate.sv */
// ilm_gate: combinational masking of the level requests
// assumes mask and raw come from the top's flip-flops
`timescale 1ns/1ns
module ilm_gate (
    ilm_gate_if.gate g
);
    import ilm_pkg::*;
    // masked level is hidden from the cpu
    assign g.visible = g.raw & g.mask;
endmodule

/* File: hw/ilm_top.sv */
// ilm_top: eight-bit interrupt level mask with wishbone access
// assumes synchronous requests and a classic wishbone master
//
// Overview of operation
// - bit 0 gates timer A level zero
// - bit 1 gates timer B level one
// - bit 5 gates all four UART events, level five
// - masked level never reaches the cpu
//
// The implementer's own choice: the Wishbone interface to the registers.
`timescale 1ns/1ns
module ilm_top #(
    parameter int LEVELS = ilm_pkg::ILM_LEVELS
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ilm_pkg::ILM_ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic timer_a_match_i,
    input wire logic timer_a_overflow_i,
    input wire logic timer_b_match_i,
    input wire logic [3:0] uart_event_i,
    input wire logic [LEVELS-1:0] other_request_i,
    output logic [LEVELS-1:0] cpu_request_o
);
    import ilm_pkg::*;

    ilm_gate_if #(.N(LEVELS)) gif ();

    ilm_gate u_ilm_gate (
        .g(gif)
    );

    ilm_state_t state_reg, state_next;
    logic [LEVELS-1:0] mask_reg, mask_next;
    logic [LEVELS-1:0] raw_reg, raw_next;
    logic [LEVELS-1:0] req_reg, req_next;
    logic [31:0] dat_reg, dat_next;
    logic ack_reg, ack_next;

    function automatic logic hit(input logic [ILM_ADDR_W-1:0] a,
                                 input logic [ILM_ADDR_W-1:0] b);
        hit = (a == b);
    endfunction

    always_comb begin
        raw_next = other_request_i;
        raw_next[ILM_BIT_TIMER_A] = timer_a_match_i | timer_a_overflow_i;
        raw_next[ILM_BIT_TIMER_B] = timer_b_match_i;
        raw_next[ILM_BIT_UART] = |uart_event_i;
    end

    assign gif.mask = mask_reg;
    assign gif.raw = raw_reg;

    always_comb begin
        state_next = state_reg;
        mask_next = mask_reg;
        dat_next = dat_reg;
        ack_next = 1'b0;
        req_next = gif.visible;
        unique case (state_reg)
            ILM_IDLE: begin
                if (wb_cyc_i && wb_stb_i) begin
                    ack_next = 1'b1;
                    state_next = ILM_ACK;
                    dat_next = ILM_ERR_DATA;
                    if (hit(wb_adr_i, ILM_MASK_ADDR)) begin
                        // write takes effect with the ack
                        if (wb_we_i && wb_sel_i[0]) begin
                            mask_next = wb_dat_i[LEVELS-1:0];
                        end
                        dat_next[LEVELS-1:0] = mask_reg;
                    end else if (hit(wb_adr_i, ILM_STATUS_ADDR)) begin
                        // raw level state, before masking
                        dat_next[LEVELS-1:0] = raw_reg;
                    end
                end
            end
            ILM_ACK: begin
                // one idle cycle so a held strobe is not acked twice
                state_next = ILM_IDLE;
            end
            default: state_next = ILM_IDLE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= ILM_IDLE;
            // mask contents undefined until written; zero chosen
            mask_reg <= LEVELS'(ILM_MASK_RESET);
            raw_reg <= '0;
            req_reg <= '0;
            dat_reg <= '0;
            ack_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            mask_reg <= mask_next;
            raw_reg <= raw_next;
            req_reg <= req_next;
            dat_reg <= dat_next;
            ack_reg <= ack_next;
        end
    end

    assign wb_dat_o = dat_reg;
    assign wb_ack_o = ack_reg;
    assign cpu_request_o = req_reg;

    // level path: raw taken at edge n, request out at n+1, seen at n+2
    a_masked_level_hidden: assert property (
        @(posedge clk_i) disable iff (rst_i)
        !(|(cpu_request_o & ~$past(mask_reg))))
        else $error("masked level reached cpu");

    a_level_from_raw: assert property (
        @(posedge clk_i) disable iff (rst_i)
        !(|(cpu_request_o & ~$past(raw_reg))))
        else $error("request without raised level");

    a_timer_a_level: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (timer_a_overflow_i && mask_reg[0] ##1 mask_reg[0]) |=> cpu_request_o[0])
        else $error("timer a level not passed");

    a_timer_a_match: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (timer_a_match_i && mask_reg[0] ##1 mask_reg[0]) |=> cpu_request_o[0])
        else $error("timer a match not passed");

    a_timer_a_quiet: assert property (
        @(posedge clk_i) disable iff (rst_i)
        !(timer_a_match_i || timer_a_overflow_i) |=> ##1 !cpu_request_o[0])
        else $error("level zero raised without timer a");

    a_timer_b_level: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (timer_b_match_i && mask_reg[1] ##1 mask_reg[1]) |=> cpu_request_o[1])
        else $error("timer b level not passed");

    a_timer_b_quiet: assert property (
        @(posedge clk_i) disable iff (rst_i)
        !timer_b_match_i |=> ##1 !cpu_request_o[1])
        else $error("level one raised without timer b");

    a_uart_level: assert property (
        @(posedge clk_i) disable iff (rst_i)
        ((|uart_event_i) && mask_reg[5] ##1 mask_reg[5]) |=> cpu_request_o[5])
        else $error("uart level not passed");

    a_uart_quiet: assert property (
        @(posedge clk_i) disable iff (rst_i)
        !(|uart_event_i) |=> ##1 !cpu_request_o[5])
        else $error("level five raised without uart");

    // bus side: one ack per taken request, data held until the next answer
    a_mask_write_takes: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0] && !ack_reg
         && state_reg == ILM_IDLE && wb_adr_i == ILM_MASK_ADDR)
        |=> wb_ack_o && mask_reg == $past(wb_dat_i[LEVELS-1:0]))
        else $error("mask write lost");

    a_sel_ignored: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (wb_cyc_i && wb_stb_i && wb_we_i && !wb_sel_i[0]) |=> $stable(mask_reg))
        else $error("mask written without byte enable");

    a_mask_stable: assert property (
        @(posedge clk_i) disable iff (rst_i)
        !(wb_cyc_i && wb_stb_i && wb_we_i) |=> $stable(mask_reg))
        else $error("mask changed without write");

    a_read_back: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (wb_cyc_i && wb_stb_i && !wb_we_i && state_reg == ILM_IDLE
         && wb_adr_i == ILM_MASK_ADDR) |=> wb_dat_o[LEVELS-1:0] == $past(mask_reg))
        else $error("mask read wrong");

    a_status_read: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (wb_cyc_i && wb_stb_i && state_reg == ILM_IDLE && wb_adr_i == ILM_STATUS_ADDR)
        |=> wb_dat_o[LEVELS-1:0] == $past(raw_reg))
        else $error("status read wrong");

    a_unmapped_zero: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (wb_cyc_i && wb_stb_i && state_reg == ILM_IDLE && wb_adr_i != ILM_MASK_ADDR
         && wb_adr_i != ILM_STATUS_ADDR) |=> wb_dat_o == ILM_ERR_DATA)
        else $error("unmapped read not zero");

    a_upper_zero: assert property (
        @(posedge clk_i) disable iff (rst_i)
        wb_dat_o[31:LEVELS] == '0)
        else $error("upper read bits not zero");

    a_dat_stable: assert property (
        @(posedge clk_i) disable iff (rst_i)
        !(wb_cyc_i && wb_stb_i && state_reg == ILM_IDLE) |=> $stable(wb_dat_o))
        else $error("read data changed without request");

    a_ack_follows: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (wb_cyc_i && wb_stb_i && state_reg == ILM_IDLE) |=> wb_ack_o)
        else $error("request not acked");

    a_ack_only_taken: assert property (
        @(posedge clk_i) disable iff (rst_i)
        !(wb_cyc_i && wb_stb_i && state_reg == ILM_IDLE) |=> !wb_ack_o)
        else $error("ack without request");

    a_ack_single: assert property (
        @(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held too long");

    a_reset_clear: assert property (
        @(posedge clk_i)
        rst_i |=> (!wb_ack_o && cpu_request_o == '0 && mask_reg == LEVELS'(ILM_MASK_RESET)))
        else $error("reset state wrong");
endmodule

/* File: testbench/ilm_cpu_model.sv */
// ilm_cpu_model: cpu side latching the levels it recognizes
// assumes requests are registered in the clk_i domain
`timescale 1ns/1ns
module ilm_cpu_model (
    input wire logic clk_i,
    input wire logic [7:0] request_i,
    output logic [7:0] seen_o
);
    // no priority or vectoring: only which levels got through
    always_ff @(posedge clk_i) begin
        seen_o <= request_i;
    end
endmodule

/* File: testbench/tb_ilm_top.sv */
// tb_ilm_top: wishbone tasks and level checks for the mask block
// assumes ilm_top, with ilm_cpu_model watching its requests
`timescale 1ns/1ns
module tb_ilm_top;
    import ilm_pkg::*;
    logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, ta = 0, tao = 0, tb = 0, ack;
    logic [9:0] adr = 0;
    logic [31:0] wd = 0, rd, dat_o;
    logic [3:0] uart = 0, sel = 4'h0;
    logic [7:0] req, seen, oth = 8'h00;
    int n_mismatch = 0, tests_run = 0, cyc_n = 0;
    always #25 clk_i = ~clk_i;
    ilm_top u_ilm_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd), .wb_dat_o(dat_o),
        .wb_ack_o(ack), .timer_a_match_i(ta), .timer_a_overflow_i(tao),
        .timer_b_match_i(tb), .uart_event_i(uart), .other_request_i(oth),
        .cpu_request_o(req));
    ilm_cpu_model u_ilm_cpu_model (.clk_i(clk_i), .request_i(req), .seen_o(seen));
    task automatic complete_run;
        if (n_mismatch == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic chk_lv(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: level got %h want %h", $time, got, exp);
        end
    endtask
    // entered just after a rising edge; ack and data read before that edge updates them
    task automatic wb(input logic w, input logic [9:0] a, input logic [31:0] d,
                      input logic [3:0] s);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wd <= d;
        sel <= s;
        do @(posedge clk_i); while (ack !== 1'b1);
        rd = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_i);
    endtask
    // raw in, two edges to the request, one more to the cpu model
    task automatic lv(input logic [1:0] t_a, input logic t_b, input logic [3:0] u,
                      input logic [7:0] o, input logic [7:0] e);
        ta <= t_a[0];
        tao <= t_a[1];
        tb <= t_b;
        uart <= u;
        oth <= o;
        repeat (3) @(posedge clk_i);
        @(negedge clk_i);
        chk_lv(req, e);
        chk_lv(seen, e);
        @(posedge clk_i);
    endtask
    always @(posedge clk_i) begin
        cyc_n <= cyc_n + 1;
        if (cyc_n == 1000) begin
            n_mismatch++;
            complete_run();
        end
    end
    initial begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        wb(1'b0, ILM_MASK_ADDR, 32'h0, 4'h1);
        chk(rd, {24'h0, ILM_MASK_RESET});
        wb(1'b1, ILM_MASK_ADDR, 32'hffff_ff21, 4'hf);
        wb(1'b0, ILM_MASK_ADDR, 32'h0, 4'h1);
        chk(rd, 32'h21);
        wb(1'b1, ILM_MASK_ADDR, 32'hff, 4'he);
        wb(1'b0, ILM_MASK_ADDR, 32'h0, 4'h1);
        chk(rd, 32'h21);
        wb(1'b1, 10'h010, 32'hff, 4'h1);
        wb(1'b0, 10'h010, 32'h0, 4'h1);
        chk(rd, 32'h0);
        wb(1'b0, ILM_MASK_ADDR, 32'h0, 4'h1);
        chk(rd, 32'h21);
        lv(2'b01, 1'b1, 4'h0, 8'h00, 8'h01);
        lv(2'b10, 1'b1, 4'h8, 8'h00, 8'h21);
        wb(1'b0, ILM_STATUS_ADDR, 32'h0, 4'h1);
        chk(rd, 32'h23);
        wb(1'b1, ILM_MASK_ADDR, 32'h02, 4'h1);
        lv(2'b11, 1'b1, 4'hf, 8'h00, 8'h02);
        lv(2'b00, 1'b0, 4'h0, 8'hff, 8'h00);
        wb(1'b1, ILM_MASK_ADDR, 32'hff, 4'h1);
        lv(2'b00, 1'b0, 4'h0, 8'hff, 8'hdc);
        complete_run();
    end
endmodule
